/* fpc_if.sv */
// carriers between the counter top and its helper units
`timescale 1ns/100ps
interface fpc_trig_if;
  logic       sig;
  logic       en;
  logic [1:0] pol;
  logic       fire;
  logic       act_on;
  logic       act_off;
  modport unit (input sig, en, pol, output fire, act_on, act_off);
  modport user (output sig, en, pol, input fire, act_on, act_off);
endinterface

interface fpc_quad_if;
  logic a;
  logic b;
  logic up;
  logic dn;
  modport unit (input a, b, output up, dn);
  modport user (output a, b, input up, dn);
endinterface

/* fpc_pkg.sv */
// constants, field layout and mode codes for the fast pulse counter
package fpc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS      = 40;
  localparam int TICK_NS     = 1000;
  localparam int TICK_CYC    = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int FREQ_WIN_MS = 1000;
  localparam int FREQ_WIN_CYC =
    int'((64'(FREQ_WIN_MS) * 64'd1000000) / 64'(CLK_NS));
  // ----------------------------------------
  // register byte offsets within one counter
  // ----------------------------------------
  localparam logic [4:0] OFS_CTRL    = 5'h00;
  localparam logic [4:0] OFS_TRIG    = 5'h04;
  localparam logic [4:0] OFS_PRELOAD = 5'h08;
  localparam logic [4:0] OFS_ACC     = 5'h0C;
  localparam logic [4:0] OFS_LATCH   = 5'h10;
  localparam int         CH_SEL_BIT  = 5;
  // ----------------------------------------
  // control register fields
  // ----------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SUB      = 4;
  localparam int CTRL_IN1_LSB  = 5;
  localparam int CTRL_IN2_LSB  = 7;
  localparam int CTRL_IN2_EN   = 9;
  localparam int CTRL_LREL     = 10;
  localparam int CTRL_SOFT     = 11;
  // ----------------------------------------
  // trigger fields: six bits per special function
  // ----------------------------------------
  localparam int TRG_W       = 6;
  localparam int TRG_POL_LSB = 0;
  localparam int TRG_SRC_LSB = 2;
  localparam int TRG_EN      = 5;
  localparam int TRG_N       = 5;
  localparam int TRG_DIS     = 0;
  localparam int TRG_CLR     = 1;
  localparam int TRG_PRE     = 2;
  localparam int TRG_LAT     = 3;
  localparam int TRG_MRK     = 4;
  localparam logic [2:0] SRC_SOFT = 3'h4;
  localparam logic [31:0] RST_WORD = 32'h00000000;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    FPC_TIMER  = 4'h0, FPC_UP     = 4'h1, FPC_DOWN   = 4'h2,
    FPC_UPDN   = 4'h3, FPC_CLKDIR = 4'h4, FPC_FREQ   = 4'h5,
    FPC_WIDTH  = 4'h6, FPC_PERIOD = 4'h7, FPC_QUAD   = 4'h8
  } fpc_mode_e;
  typedef enum logic [1:0] {
    FPC_HIGH = 2'h0, FPC_LOW = 2'h1, FPC_FALL = 2'h2, FPC_RISE = 2'h3
  } fpc_pol_e;
endpackage

/* fpc_props.sv */
// bus checker for the fast pulse counter
`timescale 1ns/100ps
module fpc_props (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [3:0]  pulse_in,
  input wire logic [7:0]  addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [31:0] rdata_out
);
  // ----
  // register mirror and quiet counters
  // ----
  logic [31:0] mir [16];
  logic [31:0] rx, lv, av, c0, t0;
  logic [3:0]  pp;
  logic [2:0]  pq, fz;
  logic        lo, ao, rl, ra, hi0, dis;
  assign c0 = mir[0];
  assign t0 = mir[1];
  assign hi0 = addr_in[7:6] == 2'h0;
  // soft level disable only, nothing else acting on the count
  assign dis = t0[5:0] == 6'h30 && c0[11] && !t0[11] && !t0[17] && !t0[29];
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 16; i++)
        mir[i] <= 32'h0;
      {rx, lv, av, pp, pq, fz, lo, ao, rl, ra} <= '0;
    end else begin
      if (wr_in && hi0)
        mir[addr_in[5:2]] <= wdata_in;
      rx <= mir[addr_in[5:2]];
      pp <= pulse_in;
      rl <= rd_in && addr_in == 8'h10;
      ra <= rd_in && addr_in == 8'h0C;
      pq <= (wr_in || pulse_in != pp) ? 3'h0 : pq + {2'h0, pq != 3'h7};
      fz <= (!dis || wr_in && !addr_in[5] && addr_in[4:2] < 3'h3) ?
            3'h0 : fz + {2'h0, fz != 3'h7};
      if (pq < 3'h4)
        lo <= 1'b0;
      else if (rl) begin
        lv <= rdata_out;
        lo <= 1'b1;
      end
      if (fz < 3'h4)
        ao <= 1'b0;
      else if (ra) begin
        av <= rdata_out;
        ao <= 1'b1;
      end
    end
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_rd_idle_zero:
    assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data outside answer cycle");
  a_rst_quiet:
    assert property ($past(rst_in) |-> rdata_out == 32'h0)
    else $error("read data right after reset");
  a_unmapped_zero:
    assert property (rd_in && (!hi0 || addr_in[1:0] != 2'h0 ||
      addr_in[4:2] > 3'h4) |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_ctrl_back:
    assert property (rd_in && hi0 && addr_in[4:0] == 5'h00
      |=> rdata_out[11:0] == rx[11:0])
    else $error("control readback wrong");
  a_trig_back:
    assert property (rd_in && hi0 && addr_in[4:0] == 5'h04
      |=> rdata_out[29:0] == rx[29:0])
    else $error("trigger readback wrong");
  a_pre_back:
    assert property (rd_in && hi0 && addr_in[4:0] == 5'h08
      |=> rdata_out == rx)
    else $error("preload readback wrong");
  a_latch_hold:
    assert property (rl && lo && pq >= 3'h4 |-> rdata_out == lv)
    else $error("latch moved without strobe");
  a_acc_frozen:
    assert property (ra && ao && fz >= 3'h4 |-> rdata_out == av)
    else $error("count moved while disabled");
endmodule

bind fpc_top fpc_props fpc_props_i (.clk_in(clk_in), .rst_in(rst_in),
  .pulse_in(pulse_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out));

/* fpc_quad.sv */
// quadrature step decoder, one step on every edge of either input
`timescale 1ns/100ps
module fpc_quad (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  fpc_quad_if.unit    q
);
  logic [1:0] ab_reg;
  logic [1:0] ab_next;
  logic       ar, af, br, bf;

  always_comb begin
    ab_next = {q.a, q.b};
    ar   = q.a & ~ab_reg[1];
    af   = ~q.a & ab_reg[1];
    br   = q.b & ~ab_reg[0];
    bf   = ~q.b & ab_reg[0];
    // a leading b counts up
    q.up = (ar & ~q.b) | (br & q.a) | (af & q.b) | (bf & ~q.a);
    q.dn = (br & ~q.a) | (ar & q.b) | (bf & q.a) | (af & ~q.b);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ab_reg <= 2'h0;
    end else begin
      ab_reg <= ab_next;
    end
  end
endmodule

/* fpc_src.sv */
// pulse and quadrature source at the counter inputs
`timescale 1ns/100ps
module fpc_src (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [3:0] tgl_in,
  input  wire logic       qs_in,
  input  wire logic       qr_in,
  output logic      [3:0] pulse_out
);
  // ----
  // lines toggle on request; lines 0 and 1 step a gray phase
  // ----
  logic [3:0] pulse_reg, pulse_next;
  logic [1:0] ph;
  assign pulse_out = pulse_reg;
  always_comb begin
    ph = {pulse_reg[1], pulse_reg[1] ^ pulse_reg[0]};
    ph = qr_in ? ph - 2'h1 : ph + 2'h1;
    pulse_next = pulse_reg ^ tgl_in;
    if (qs_in)
      pulse_next[1:0] = {ph[1], ph[1] ^ ph[0]};
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in)
      pulse_reg <= 4'h0;
    else
      pulse_reg <= pulse_next;
  end
endmodule

/* fpc_top.sv */
// two-channel fast pulse counter with special functions
// Function
// - Offer timer, frequency, totalize, width or period, quadrature functions.
// - Keep an accumulator with the running count of input events.
// - Clear zeroes the accumulator; not in frequency or period. The code also ignores it in width.
// - While disable is asserted, input events do not change the count.
// - Preload loads the configured value; not in frequency or period. The code also ignores it in width.
// - Latch strobe captures; output moves at once or on release.
// - Latched output holds until the strobe becomes active again.
// - Each special function triggers on high, low, falling or rising.
// - Accept a marker input as a reference position.
// - Totalizer sums input cycles into the accumulator.
// - Two counters share four fast inputs; some modes use two.
// - Quadrature counts every edge of both inputs, direction by lead.
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module fpc_top #(
  parameter int FREQ_WIN_CYC = fpc_pkg::FREQ_WIN_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [3:0]  pulse_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out
);
  localparam int NCH = 2;

  // ----------------------------------------
  // shared time base and input history
  // ----------------------------------------
  logic [3:0]  prev_reg;
  logic [3:0]  prev_next;
  logic [4:0]  us_reg;
  logic [4:0]  us_next;
  logic [31:0] win_reg;
  logic [31:0] win_next;
  logic        us_tick;
  logic        win_tick;
  logic [3:0]  rise;
  logic [3:0]  fall;

  always_comb begin
    prev_next = pulse_in;
    rise      = pulse_in & ~prev_reg;
    fall      = ~pulse_in & prev_reg;
    us_tick   = (us_reg == 5'(fpc_pkg::TICK_CYC - 1));
    us_next   = us_tick ? 5'h00 : us_reg + 5'h01;
    win_tick  = (win_reg == 32'(FREQ_WIN_CYC - 1));
    win_next  = win_tick ? 32'h00000000 : win_reg + 32'h00000001;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_reg <= 4'h0;
      us_reg   <= 5'h00;
      win_reg  <= 32'h00000000;
    end else begin
      prev_reg <= prev_next;
      us_reg   <= us_next;
      win_reg  <= win_next;
    end
  end

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic [31:0] ctrl_reg    [NCH];
  logic [31:0] trig_reg    [NCH];
  logic [31:0] preload_reg [NCH];
  logic [31:0] acc_reg     [NCH];
  logic [31:0] latch_reg   [NCH];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rch;
  logic [4:0]  rofs;

  always_comb begin
    rch        = addr_in[fpc_pkg::CH_SEL_BIT];
    rofs       = addr_in[4:0];
    rdata_next = 32'h00000000;
    // read data stand one cycle only; unmapped reads give zero
    if (rd_in && (addr_in[7:6] == 2'h0)) begin
      case (rofs)
        fpc_pkg::OFS_CTRL:    rdata_next = ctrl_reg[rch];
        fpc_pkg::OFS_TRIG:    rdata_next = trig_reg[rch];
        fpc_pkg::OFS_PRELOAD: rdata_next = preload_reg[rch];
        fpc_pkg::OFS_ACC:     rdata_next = acc_reg[rch];
        fpc_pkg::OFS_LATCH:   rdata_next = latch_reg[rch];
        default:              rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= fpc_pkg::RST_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // ----------------------------------------
  // counter channels
  // ----------------------------------------
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    fpc_trig_if tif[fpc_pkg::TRG_N] ();
    fpc_quad_if qif ();

    logic [31:0] ctrl_next;
    logic [31:0] trig_next;
    logic [31:0] preload_next;
    logic [31:0] acc_next;
    logic [31:0] latch_next;
    logic [31:0] held_reg;
    logic [31:0] held_next;
    logic [31:0] meas_reg;
    logic [31:0] meas_next;
    logic        wsel;
    logic [3:0]  mode;
    logic        sub;
    logic [1:0]  in1;
    logic [1:0]  in2;
    logic        lvl1;
    logic        lvl2;
    logic        r1;
    logic        f1;
    logic        r2;
    logic        step_up;
    logic        step_dn;
    logic        dis;
    logic        clr_hit;
    logic        pre_hit;
    logic        mrk_hit;
    logic        meas_mode;

    // one helper per special function, fed from an assigned input
    for (genvar k = 0; k < fpc_pkg::TRG_N; k++) begin : g_trg
      logic [2:0] src;
      assign src = trig_reg[c][k*fpc_pkg::TRG_W+fpc_pkg::TRG_SRC_LSB +: 3];
      assign tif[k].sig = (src == fpc_pkg::SRC_SOFT) ?
                          ctrl_reg[c][fpc_pkg::CTRL_SOFT] :
                          pulse_in[src[1:0]];
      assign tif[k].en  = trig_reg[c][k*fpc_pkg::TRG_W+fpc_pkg::TRG_EN] &
                          (src <= fpc_pkg::SRC_SOFT);
      assign tif[k].pol = trig_reg[c][k*fpc_pkg::TRG_W+fpc_pkg::TRG_POL_LSB +: 2];
      fpc_trig u_trig (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .t      (tif[k])
      );
    end

    fpc_quad u_quad (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .q      (qif)
    );

    // register writes
    always_comb begin
      wsel = wr_in && (addr_in[7:6] == 2'h0) &&
             (addr_in[fpc_pkg::CH_SEL_BIT] == 1'(c));
      ctrl_next    = ctrl_reg[c];
      trig_next    = trig_reg[c];
      preload_next = preload_reg[c];
      if (wsel) begin
        case (addr_in[4:0])
          fpc_pkg::OFS_CTRL:    ctrl_next    = wdata_in;
          fpc_pkg::OFS_TRIG:    trig_next    = wdata_in;
          fpc_pkg::OFS_PRELOAD: preload_next = wdata_in;
          default:              ctrl_next    = ctrl_reg[c];
        endcase
      end
    end

    // input selection and stepping
    always_comb begin
      mode    = ctrl_reg[c][fpc_pkg::CTRL_MODE_LSB +: 4];
      sub     = ctrl_reg[c][fpc_pkg::CTRL_SUB];
      in1     = ctrl_reg[c][fpc_pkg::CTRL_IN1_LSB +: 2];
      in2     = ctrl_reg[c][fpc_pkg::CTRL_IN2_LSB +: 2];
      lvl1    = pulse_in[in1];
      lvl2    = pulse_in[in2];
      r1      = rise[in1];
      f1      = fall[in1];
      r2      = rise[in2] & ctrl_reg[c][fpc_pkg::CTRL_IN2_EN];
      qif.a   = lvl1;
      qif.b   = lvl2;
      step_up = 1'b0;
      step_dn = 1'b0;
      case (mode)
        fpc_pkg::FPC_TIMER: begin
          step_up = us_tick;
        end
        fpc_pkg::FPC_UP: begin
          step_up = r1 | r2;
        end
        fpc_pkg::FPC_DOWN: begin
          step_dn = r1 | r2;
        end
        fpc_pkg::FPC_UPDN: begin
          step_up = r1;
          step_dn = r2;
        end
        fpc_pkg::FPC_CLKDIR: begin
          step_up = r1 & ~lvl2;
          step_dn = r1 & lvl2;
        end
        fpc_pkg::FPC_QUAD: begin
          // sub selects counting down when input 1 leads
          step_up = sub ? qif.dn : qif.up;
          step_dn = sub ? qif.up : qif.dn;
        end
        default: begin
          step_up = 1'b0;
        end
      endcase
    end

    // special function qualification
    always_comb begin
      meas_mode = (mode == fpc_pkg::FPC_FREQ) ||
                  (mode == fpc_pkg::FPC_WIDTH) ||
                  (mode == fpc_pkg::FPC_PERIOD);
      dis     = tif[fpc_pkg::TRG_DIS].fire;
      clr_hit = tif[fpc_pkg::TRG_CLR].fire &
                (mode != fpc_pkg::FPC_FREQ) &&
                (mode != fpc_pkg::FPC_PERIOD);
      pre_hit = tif[fpc_pkg::TRG_PRE].fire &
                (mode != fpc_pkg::FPC_FREQ) &&
                (mode != fpc_pkg::FPC_PERIOD);
      mrk_hit = tif[fpc_pkg::TRG_MRK].fire &
                (mode == fpc_pkg::FPC_QUAD);
    end

    // accumulator, measurement and latch
    always_comb begin
      acc_next   = acc_reg[c];
      meas_next  = meas_reg;
      held_next  = held_reg;
      latch_next = latch_reg[c];
      if (meas_mode) begin
        if (!dis) begin
          case (mode)
            fpc_pkg::FPC_FREQ: begin
              // edges in a one-second window give hertz
              if (win_tick) begin
                acc_next  = meas_reg;
                meas_next = {31'h00000000, r1};
              end else if (r1) begin
                meas_next = meas_reg + 32'h00000001;
              end
            end
            fpc_pkg::FPC_WIDTH: begin
              // sub measures the low phase instead of the high one
              if (sub ? r1 : f1) begin
                acc_next  = meas_reg;
                meas_next = 32'h00000000;
              end else if ((sub ? ~lvl1 : lvl1) && us_tick) begin
                meas_next = meas_reg + 32'h00000001;
              end
            end
            fpc_pkg::FPC_PERIOD: begin
              // sub starts each period on the falling edge
              if (sub ? f1 : r1) begin
                acc_next  = meas_reg;
                meas_next = 32'h00000000;
              end else if (us_tick) begin
                meas_next = meas_reg + 32'h00000001;
              end
            end
            default: begin
              meas_next = meas_reg;
            end
          endcase
        end
      end else if (clr_hit || mrk_hit) begin
        acc_next = 32'h00000000;
      end else if (pre_hit) begin
        acc_next = preload_reg[c];
      end else if (!dis) begin
        // opposite steps in one cycle cancel
        if (step_up && !step_dn) begin
          acc_next = acc_reg[c] + 32'h00000001;
        end else if (step_dn && !step_up) begin
          acc_next = acc_reg[c] - 32'h00000001;
        end
      end
      // when disabled the value stays unless clear, marker or preload hits
      if (tif[fpc_pkg::TRG_LAT].act_on) begin
        held_next = acc_reg[c];
        if (!ctrl_reg[c][fpc_pkg::CTRL_LREL]) begin
          latch_next = acc_reg[c];
        end
      end else if (tif[fpc_pkg::TRG_LAT].act_off &&
                   ctrl_reg[c][fpc_pkg::CTRL_LREL]) begin
        latch_next = held_reg;
      end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        ctrl_reg[c]    <= fpc_pkg::RST_WORD;
        trig_reg[c]    <= fpc_pkg::RST_WORD;
        preload_reg[c] <= fpc_pkg::RST_WORD;
        acc_reg[c]     <= fpc_pkg::RST_WORD;
        latch_reg[c]   <= fpc_pkg::RST_WORD;
        held_reg       <= fpc_pkg::RST_WORD;
        meas_reg       <= fpc_pkg::RST_WORD;
      end else begin
        ctrl_reg[c]    <= ctrl_next;
        trig_reg[c]    <= trig_next;
        preload_reg[c] <= preload_next;
        acc_reg[c]     <= acc_next;
        latch_reg[c]   <= latch_next;
        held_reg       <= held_next;
        meas_reg       <= meas_next;
      end
    end
  end
endmodule

/* fpc_trig.sv */
// trigger condition of one special function
`timescale 1ns/100ps
module fpc_trig (
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  fpc_trig_if.unit    t
);
  logic lvl;
  logic lvl_reg;
  logic lvl_next;

  // high and rising are active while high, low and falling while low
  always_comb begin
    lvl = t.en & ((t.pol == fpc_pkg::FPC_HIGH) ||
                  (t.pol == fpc_pkg::FPC_RISE) ? t.sig : ~t.sig);
    lvl_next  = lvl;
    t.act_on  = lvl & ~lvl_reg;
    t.act_off = ~lvl & lvl_reg;
    // level polarities fire every cycle, edge polarities once
    t.fire    = (t.pol == fpc_pkg::FPC_HIGH) ||
                (t.pol == fpc_pkg::FPC_LOW) ? lvl : t.act_on;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lvl_reg <= 1'b0;
    end else begin
      lvl_reg <= lvl_next;
    end
  end
endmodule

/* test_fpc_top.sv */
// testbench for the fast pulse counter
`timescale 1ns/100ps
module test_fpc_top;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [3:0]  pulse_in;
  logic [7:0]  addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [31:0] rdata_out, e;
  logic [3:0]  tgl = 4'h0;
  logic        qs = 1'b0;
  logic        qr = 1'b0;
  logic        i;
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;
  always #20 clk_in = ~clk_in;
  fpc_top #(.FREQ_WIN_CYC(100)) fpc_top_i (.clk_in(clk_in),
    .rst_in(rst_in), .pulse_in(pulse_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out));
  fpc_src fpc_src_i (.clk_in(clk_in), .rst_in(rst_in), .tgl_in(tgl),
    .qs_in(qs), .qr_in(qr), .pulse_out(pulse_in));
  // ----
  // tasks
  // ----
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    checks++;
    if (s !== x) begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] x, string n);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(n, rdata_out, x);
  endtask
  // toggle lines m, or step quadrature when q, n times
  task automatic st(logic [3:0] m, logic q, logic r, int n);
    repeat (n) begin
      @(posedge clk_in);
      tgl <= m;
      qs <= q;
      qr <= r;
      @(posedge clk_in);
      tgl <= 4'h0;
      qs <= 1'b0;
    end
    repeat (3) @(posedge clk_in);
  endtask
  // one pulse on line 3, high for h + 1 cycles
  task automatic pw(int h);
    @(posedge clk_in);
    tgl <= 4'h8;
    @(posedge clk_in);
    tgl <= 4'h0;
    repeat (h) @(posedge clk_in);
    tgl <= 4'h8;
    @(posedge clk_in);
    tgl <= 4'h0;
    repeat (3) @(posedge clk_in);
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_total++;
      test_done();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    repeat (4) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int c = 0; c < 2; c++)
      for (int o = 0; o < 5; o++)
        if (o != 3)
          rd(8'(c * 32 + o * 4), 32'h0, "reset value");
    rd(8'h14, 32'h0, "unmapped 14");
    rd(8'h42, 32'h0, "unmapped 42");
    for (int c = 0; c < 2; c++) begin
      e = c ? 32'h042 : 32'h001;
      wr(8'(c * 32), e);
      wr(8'(c * 32 + 4), 32'hC00);
      wr(8'(c * 32), e | 32'h800);
      wr(8'(c * 32 + 4), 32'h0);
      wr(8'(c * 32), e);
      rd(8'(c * 32 + 12), 32'h0, "acc cleared");
    end
    st(4'h5, 1'b0, 1'b0, 6);
    rd(8'h0C, 32'h3, "acc up");
    rd(8'h2C, 32'hFFFFFFFD, "acc down");
    e = 32'h3;
    for (int p = 0; p < 4; p++) begin
      i = (p == 1 || p == 2);
      wr(8'h00, {20'h0, i, 11'h001});
      wr(8'h04, 32'(6'h30 + p) << 6);
      st(4'h1, 1'b0, 1'b0, 4);
      rd(8'h0C, e + 32'h2, "acc trig idle");
      wr(8'h00, {20'h0, !i, 11'h001});
      st(4'h1, 1'b0, 1'b0, 2);
      e = (p > 1) ? 32'h1 : 32'h0;
      rd(8'h0C, e, "acc trig hit");
    end
    wr(8'h08, 32'h100);
    wr(8'h00, 32'h001);
    wr(8'h04, 32'h33000);
    wr(8'h00, 32'h801);
    rd(8'h0C, 32'h100, "acc preload");
    rd(8'h08, 32'h100, "preload reg");
    wr(8'h04, 32'h30);
    st(4'h1, 1'b0, 1'b0, 4);
    rd(8'h0C, 32'h100, "acc disabled");
    wr(8'h0C, 32'h55);
    rd(8'h0C, 32'h100, "acc no write");
    wr(8'h00, 32'h001);
    st(4'h1, 1'b0, 1'b0, 2);
    rd(8'h0C, 32'h101, "acc resumed");
    wr(8'h04, 32'h00CC0000);
    wr(8'h00, 32'h801);
    rd(8'h10, 32'h101, "latch now");
    st(4'h1, 1'b0, 1'b0, 2);
    rd(8'h10, 32'h101, "latch held");
    rd(8'h10, 32'h101, "latch held");
    wr(8'h00, 32'h401);
    wr(8'h00, 32'hC01);
    st(4'h1, 1'b0, 1'b0, 2);
    rd(8'h10, 32'h101, "latch pending");
    wr(8'h00, 32'h401);
    rd(8'h10, 32'h102, "latch release");
    rd(8'h0C, 32'h103, "acc counting");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h005);
    @(posedge clk_in);
    tgl <= 4'h1;
    repeat (400) @(posedge clk_in);
    rd(8'h0C, 32'h32, "frequency");
    tgl <= 4'h0;
    wr(8'h20, 32'h088);
    wr(8'h24, 32'h2B000000);
    st(4'h4, 1'b0, 1'b0, 1);
    rd(8'h2C, 32'h0, "marker");
    st(4'h0, 1'b1, 1'b0, 8);
    rd(8'h2C, 32'h8, "quad up");
    st(4'h0, 1'b1, 1'b1, 3);
    rd(8'h2C, 32'h5, "quad back");
    st(4'h4, 1'b0, 1'b0, 2);
    rd(8'h2C, 32'h0, "marker again");
    wr(8'h20, 32'h098);
    st(4'h0, 1'b1, 1'b0, 4);
    rd(8'h2C, 32'hFFFFFFFC, "quad sub");
    wr(8'h00, 32'h066);
    pw(9);
    pw(99);
    rd(8'h0C, 32'h4, "width high");
    wr(8'h00, 32'h067);
    pw(95);
    pw(9);
    rd(8'h0C, 32'h4, "period");
    wr(8'h00, 32'h363);
    st(4'h8, 1'b0, 1'b0, 4);
    st(4'h4, 1'b0, 1'b0, 2);
    rd(8'h0C, 32'h5, "up down");
    wr(8'h00, 32'h164);
    st(4'h8, 1'b0, 1'b0, 2);
    rd(8'h0C, 32'h4, "clock dir");
    rd(8'h20, 32'h098, "ctrl back");
    rd(8'h24, 32'h2B000000, "trig back");
    test_done();
  end
endmodule
